// ### wws_pkg.sv
// Package: constants for the window watchdog and reset supervisor
//
// Overview of operation
// [R1] Too slow or fast clear: resets and fault low
// [R2] Register bit enables too-fast detection separately
// [R3] Select pin gates watchdog; disabled holds secondary reset
// [R4] Register bit: latch or pulse resets on error
// [R5] Fifth watchdog reset latches both resets low
// [R6] Reset counter cleared by clear, select, disable
// [R7] Ten consecutive too-fast detections force reset, fault
// [R8] Fast counter cleared by reset, clear, select, disable
// [R9] Interval counter restarts on clear, reset, detection, select
// [R10] Start-up window; first clear pulse starts monitoring
// [R11] Five start-up resets without clear latch off
// [R12] Disabled watchdog skips the start-up window
// [R13] Secondary reset released after in-window clear pulse
// [R14] Regulator good starts delay; then primary reset high
// [R15] Regulator drop: both resets low; recovery via delay
// [R16] Primary reset low always lasts full delay
// [R17] Reset pin mismatch: resets released, fault latched
// [R18] Any abnormality latches fault and status bit together
// [R19] Fault pin mismatch flags abnormality, latches fault
// [R20] Fault high only when all normal and cleared
// [R21] Oscillator fault: supplies off, resets low, fault
// [R22] Logic runs from nominal 50 MHz oscillator
// [R23] Timeouts and delays are configurable cycle counts
package wws_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned STARTUP_WIN_MS = 256;
  localparam longint unsigned STARTUP_WIN_CYC = longint'(STARTUP_WIN_MS) * CLK_HZ / 1000;
  localparam int unsigned SLOW_CYC_DEF = 1_000_000;
  localparam int unsigned FAST_CYC_DEF = 50_000;
  localparam int unsigned POR_CYC_DEF = 500_000;
  localparam int unsigned RST_PULSE_CYC = 64;
  localparam int unsigned RST_LATCH_CNT = 5;
  localparam int unsigned FAST_LIMIT = 10;

  // ------------------------------------------------------------
  // Register map (word addresses on the plain port)
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_STATE = 4'h2;
  localparam int CTRL_FAST_EN = 0;
  localparam int CTRL_LATCH = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Status bits (write one to clear)
  localparam int ST_SLOW = 0;
  localparam int ST_FAST = 1;
  localparam int ST_RCNT = 2;
  localparam int ST_RPIN = 3;
  localparam int ST_FPIN = 4;
  localparam int ST_OSC = 5;
  localparam int ST_UV = 6;
  localparam int ST_W = 7;

  // Watchdog phase
  typedef enum logic [3:0] {
    WWS_OFF = 4'h1,
    WWS_WAIT = 4'h2,
    WWS_RUN = 4'h4,
    WWS_LOCK = 4'h8
  } wws_state_t;

endpackage : wws_pkg

// ### wws_supervisor.sv
// Module: window watchdog, power-on reset and fault logic
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module wws_supervisor
  import wws_pkg::*;
#(
  parameter int unsigned SLOW_CYC = SLOW_CYC_DEF, // R23
  parameter int unsigned FAST_CYC = FAST_CYC_DEF, // R23
  parameter int unsigned POR_CYC = POR_CYC_DEF, // R23
  parameter longint unsigned STARTUP_CYC = STARTUP_WIN_CYC
) (
  // Clock and reset
  input wire logic i_clk, // R22
  input wire logic i_rstn,
  // Asynchronous pins and analog monitors
  input wire logic i_clear_pulse,
  input wire logic i_select_pin,
  input wire logic i_regulator_low,
  input wire logic i_osc_fault,
  input wire logic i_primary_pin,
  input wire logic i_secondary_pin,
  input wire logic i_fault_pin,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Outputs
  output logic o_primary_reset_out_n,
  output logic o_secondary_reset_out_n,
  output logic o_fault_indicator_out_n,
  output logic o_supply_off_latch
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (FAST_CYC < 1 || FAST_CYC >= SLOW_CYC) begin : g_chk_win
    $error("fast interval must be below slow timeout");
  end
  if (POR_CYC < 1 || STARTUP_CYC < 1 || SLOW_CYC > 32'hffff_fff0) begin : g_chk_cnt
    $error("bad cycle counts");
  end

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NS = 7;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NS-1:0] raw;
  assign raw = {i_clear_pulse, i_select_pin, i_regulator_low, i_osc_fault,
                i_primary_pin, i_secondary_pin, i_fault_pin};

  // Two stages; only the second is read
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= 7'h01; // Idle pin levels: only the fault pin high
      sync2_r <= 7'h01;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  logic ck_s, sel_s, uv_s, osc_s, p_pin, s_pin, f_pin;
  assign {ck_s, sel_s, uv_s, osc_s, p_pin, s_pin, f_pin} = sync2_r;

  // Clear pulse rising edge and select rising edge
  logic ck_d_r, sel_d_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ck_d_r <= 1'b0;
      sel_d_r <= 1'b0;
    end else begin
      ck_d_r <= ck_s;
      sel_d_r <= sel_s;
    end
  end
  logic ck_edge, sel_rise, wd_en;
  assign ck_edge = ck_s & ~ck_d_r;
  assign sel_rise = sel_s & ~sel_d_r;
  assign wd_en = ~sel_s; // R3

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic [1:0] ctrl_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= CTRL_RESET;
    end else if (i_wr && i_addr == ADDR_CTRL) begin
      ctrl_r <= i_wdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Power-on reset timer
  // ------------------------------------------------------------
  logic [31:0] por_cnt_r;
  logic por_done_r;
  logic prim_int_n;
  // Any drop or low primary restarts the full delay
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      por_cnt_r <= 32'h0;
      por_done_r <= 1'b0;
    end else if (uv_s || osc_s) begin
      por_cnt_r <= 32'h0; // R15
      por_done_r <= 1'b0;
    end else if (!prim_int_n && por_done_r) begin
      por_cnt_r <= 32'h0; // R16
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      if (por_cnt_r >= POR_CYC - 1) begin
        por_done_r <= 1'b1; // R14
      end else begin
        por_cnt_r <= por_cnt_r + 32'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Watchdog state and counters
  // ------------------------------------------------------------
  wws_state_t st_r;
  logic [31:0] int_cnt_r;
  logic [63:0] start_cnt_r;
  logic [3:0] fast_cnt_r;
  logic [2:0] rst_cnt_r;
  logic [6:0] pulse_r;
  logic wd_low_r; // Watchdog drives resets low
  logic released_r; // Secondary released after good clear
  logic slow_det, fast_det, fast_lim, start_to, wd_err, normal_ck;

  assign slow_det = (st_r == WWS_RUN) && int_cnt_r >= SLOW_CYC - 1; // R1
  assign fast_det = (st_r == WWS_RUN) && ck_edge && ctrl_r[CTRL_FAST_EN]
                    && int_cnt_r < FAST_CYC; // R2
  assign normal_ck = (st_r == WWS_RUN) && ck_edge && !fast_det && !wd_low_r;
  assign fast_lim = fast_det && fast_cnt_r == 4'(FAST_LIMIT - 1); // R7
  assign start_to = (st_r == WWS_WAIT) && !wd_low_r && start_cnt_r >= STARTUP_CYC - 1; // R10
  assign wd_err = slow_det || fast_lim || start_to;

  // Phase machine; a disabled watchdog never waits
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= WWS_OFF;
    end else begin
      case (st_r)
        WWS_OFF: if (wd_en && por_done_r) st_r <= WWS_WAIT; // R12
        WWS_WAIT: begin
          if (!wd_en || !por_done_r) st_r <= WWS_OFF;
          else if (wd_err && rst_cnt_r == 3'(RST_LATCH_CNT - 1)) st_r <= WWS_LOCK; // R11
          else if (ck_edge && !wd_low_r) st_r <= WWS_RUN; // R10
        end
        WWS_RUN: begin
          if (!wd_en || !por_done_r) st_r <= WWS_OFF;
          else if (wd_err && rst_cnt_r == 3'(RST_LATCH_CNT - 1)) st_r <= WWS_LOCK; // R5
        end
        WWS_LOCK: st_r <= WWS_LOCK; // R5
        default: st_r <= WWS_OFF;
      endcase
    end
  end

  // Interval and start-up counters
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      int_cnt_r <= 32'h0;
      start_cnt_r <= 64'h0;
    end else begin
      if (st_r != WWS_RUN || ck_edge || wd_err || wd_low_r || !wd_en) begin
        int_cnt_r <= 32'h0; // R9
      end else begin
        int_cnt_r <= int_cnt_r + 32'h1;
      end
      if (st_r != WWS_WAIT || wd_low_r || !wd_en) begin
        start_cnt_r <= 64'h0;
      end else begin
        start_cnt_r <= start_cnt_r + 64'h1;
      end
    end
  end

  // Too-fast counter
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fast_cnt_r <= 4'h0;
    end else if (!wd_en || sel_rise || normal_ck || wd_low_r || fast_lim) begin
      fast_cnt_r <= 4'h0; // R8
    end else if (fast_det) begin
      fast_cnt_r <= fast_cnt_r + 4'h1; // R7
    end
  end

  // Watchdog reset counter; halts at latch value
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_cnt_r <= 3'h0;
    end else if (st_r == WWS_LOCK) begin
      rst_cnt_r <= rst_cnt_r; // R5
    end else if (!wd_en || sel_rise || normal_ck || (st_r == WWS_WAIT && ck_edge && !wd_low_r)) begin
      rst_cnt_r <= 3'h0; // R6
    end else if (wd_err) begin
      rst_cnt_r <= rst_cnt_r + 3'h1;
    end
  end

  // Reset pulse or latch after an error
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wd_low_r <= 1'b0;
      pulse_r <= 7'h0;
    end else if (!wd_en && st_r != WWS_LOCK) begin
      wd_low_r <= 1'b0;
      pulse_r <= 7'h0;
    end else if (wd_err) begin
      wd_low_r <= 1'b1; // R1
      pulse_r <= 7'(RST_PULSE_CYC);
    end else if (wd_low_r && !ctrl_r[CTRL_LATCH] && st_r != WWS_LOCK) begin
      if (pulse_r == 7'h0) wd_low_r <= 1'b0; // R4
      else pulse_r <= pulse_r - 7'h1;
    end
  end

  // Secondary release once a good in-window clear arrives
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      released_r <= 1'b0;
    end else if (st_r != WWS_RUN || wd_err || wd_low_r) begin
      released_r <= 1'b0;
    end else if (normal_ck && int_cnt_r >= FAST_CYC) begin
      released_r <= 1'b1; // R13
    end
  end

  // ------------------------------------------------------------
  // Error logic and status
  // ------------------------------------------------------------
  logic [ST_W-1:0] stat_r;
  logic [ST_W-1:0] ev;
  logic pin_mis_r;
  logic fault_n_r;
  logic osc_latch_r;
  logic sec_int_n;
  logic prim_q_r, sec_q_r;
  assign prim_int_n = por_done_r && !wd_low_r && !osc_latch_r; // R15
  assign sec_int_n = prim_int_n && released_r && wd_en; // R3

  // Intent delayed to match pin synchroniser latency
  logic [2:0] pd_r, sd_r, fd_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pd_r <= 3'h0;
      sd_r <= 3'h0;
      fd_r <= 3'h7; // Fault output resets high
    end else begin
      pd_r <= {pd_r[1:0], o_primary_reset_out_n};
      sd_r <= {sd_r[1:0], o_secondary_reset_out_n};
      fd_r <= {fd_r[1:0], o_fault_indicator_out_n};
    end
  end

  always_comb begin
    ev = '0;
    ev[ST_SLOW] = slow_det || start_to;
    ev[ST_FAST] = fast_lim;
    ev[ST_RCNT] = wd_err && rst_cnt_r == 3'(RST_LATCH_CNT - 1);
    ev[ST_RPIN] = (p_pin != pd_r[2]) || (s_pin != sd_r[2]); // R17
    ev[ST_FPIN] = f_pin != fd_r[2]; // R19
    ev[ST_OSC] = osc_s; // R21
    ev[ST_UV] = uv_s;
  end

  // Status: set beats write-one-to-clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_r <= '0;
    end else if (i_wr && i_addr == ADDR_STAT) begin
      stat_r <= (stat_r & ~i_wdata[ST_W-1:0]) | ev; // R18
    end else begin
      stat_r <= stat_r | ev; // R18
    end
  end

  // Fault latch, pin-monitor release and oscillator off-latch
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault_n_r <= 1'b1;
      pin_mis_r <= 1'b0;
      osc_latch_r <= 1'b0;
      prim_q_r <= 1'b0;
      sec_q_r <= 1'b0;
    end else begin
      if (|ev) fault_n_r <= 1'b0; // R18
      else if (stat_r == '0) fault_n_r <= 1'b1; // R20
      if (ev[ST_RPIN]) pin_mis_r <= 1'b1; // R17
      if (osc_s) osc_latch_r <= 1'b1; // R21
      prim_q_r <= prim_int_n;
      sec_q_r <= sec_int_n;
    end
  end

  // Pin outputs; a reset pin mismatch releases both resets to off
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_primary_reset_out_n <= 1'b0;
      o_secondary_reset_out_n <= 1'b0;
      o_fault_indicator_out_n <= 1'b1;
      o_supply_off_latch <= 1'b0;
    end else begin
      o_primary_reset_out_n <= prim_q_r || pin_mis_r; // R17
      o_secondary_reset_out_n <= sec_q_r || pin_mis_r;
      o_fault_indicator_out_n <= fault_n_r && !(|ev);
      o_supply_off_latch <= osc_latch_r || osc_s; // R21
    end
  end

  // ------------------------------------------------------------
  // Read port, data one cycle after strobe
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CTRL: o_rdata <= {6'h00, ctrl_r};
        ADDR_STAT: o_rdata <= {1'b0, stat_r};
        ADDR_STATE: o_rdata <= {1'b0, rst_cnt_r, st_r};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule : wws_supervisor
`default_nettype wire

// ### wws_supervisor_assertions.sv
// Checker: port-level properties of the watchdog and reset supervisor
`timescale 1ns/100ps
`default_nettype none
module wws_supervisor_assertions
  import wws_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_CYC_DEF
) (
  // Clock, reset and monitored inputs
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_select_pin,
  input wire logic i_regulator_low,
  input wire logic i_osc_fault,
  input wire logic i_rd,
  // Observed outputs
  input wire logic [7:0] o_rdata,
  input wire logic o_primary_reset_out_n,
  input wire logic o_secondary_reset_out_n,
  input wire logic o_fault_indicator_out_n,
  input wire logic o_supply_off_latch
);
  int unsigned low_cnt;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // ------------------------------------------------------------
  // Primary reset low time
  // ------------------------------------------------------------
  // Saturates at the delay so a long lock never wraps it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cnt <= 0;
    end else if (o_primary_reset_out_n) begin
      low_cnt <= 0;
    end else if (low_cnt < POR_CYC) begin
      low_cnt <= low_cnt + 1;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  osc_latch_a: assert property (
    i_osc_fault |-> ##[1:8] (o_supply_off_latch && !o_fault_indicator_out_n && !o_primary_reset_out_n))
    else $error("oscillator fault not latched");
  supply_hold_a: assert property (
    o_supply_off_latch |=> o_supply_off_latch) else $error("supply latch released");
  reg_drop_a: assert property (
    i_regulator_low [*8] |-> !o_primary_reset_out_n && !o_secondary_reset_out_n) else $error("reset high on drop");
  uv_fault_a: assert property (
    i_regulator_low [*8] |-> !o_fault_indicator_out_n) else $error("fault high on drop");
  por_hold_a: assert property (
    $rose(o_primary_reset_out_n) |-> low_cnt >= POR_CYC) else $error("primary reset too short");
  select_off_a: assert property (
    i_select_pin [*8] |-> !o_secondary_reset_out_n) else $error("secondary reset high while off");
  fault_rise_a: assert property (
    $rose(o_fault_indicator_out_n) |-> !i_regulator_low && !o_supply_off_latch) else $error("fault released early");
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data without read");
  // Main scenarios reached
  cover property ($rose(o_secondary_reset_out_n));
  cover property ($rose(o_supply_off_latch));
  cover property ($fell(o_primary_reset_out_n));
endmodule : wws_supervisor_assertions
bind wws_supervisor wws_supervisor_assertions #(.POR_CYC(POR_CYC)) u_wws_chk (
  .i_clk, .i_rstn, .i_select_pin, .i_regulator_low, .i_osc_fault, .i_rd, .o_rdata,
  .o_primary_reset_out_n, .o_secondary_reset_out_n, .o_fault_indicator_out_n, .o_supply_off_latch
);
`default_nettype wire

// ### wws_mcu_model.sv
// Partner model: microcontroller sending watchdog clear pulses
`timescale 1ns/100ps
`default_nettype none
module wws_mcu_model (
  // Clock and pacing
  input wire logic i_clk,
  input wire logic [15:0] i_period,
  // Clear pulse pin
  output logic o_clear_pulse
);
  logic [15:0] cnt_r;
  // Pace counter; a zero period models a hung program
  always_ff @(posedge i_clk) begin
    if (i_period == 16'h0000 || cnt_r >= i_period - 16'h0001) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  // Four cycles wide so the synchroniser never misses it
  assign o_clear_pulse = (i_period != 16'h0000) && (cnt_r < 16'h0004);
endmodule : wws_mcu_model
`default_nettype wire

// ### tb_top.sv
// Testbench: watchdog, power-on reset and fault supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import wws_pkg::*;
  typedef struct packed {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] e;} wws_row_t;
  localparam int POR = 'h32;
  logic i_clk, i_rstn, i_select_pin, i_regulator_low, i_osc_fault, i_wr, i_rd, clr;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic o_primary_reset_out_n, o_secondary_reset_out_n, o_fault_indicator_out_n, o_supply_off_latch;
  logic [2:0] flip, pins_r;
  logic [15:0] period;
  wire logic [3:0] outs;
  int fails, comparisons;
  wws_row_t rows [5] = '{
    '{ADDR_CTRL, 1'b0, 8'h00, 8'h01},
    '{ADDR_CTRL, 1'b1, 8'h02, 8'h02},
    '{ADDR_CTRL, 1'b1, 8'h01, 8'h01},
    '{4'hf, 1'b1, 8'h5a, 8'h00},
    '{ADDR_STAT, 1'b0, 8'h00, 8'h00}
  };
  assign outs = {o_primary_reset_out_n, o_secondary_reset_out_n, o_fault_indicator_out_n, o_supply_off_latch};
  wws_supervisor #(.SLOW_CYC(32'h190), .FAST_CYC(32'h28), .POR_CYC(POR), .STARTUP_CYC(64'h3e8)) dut (
    .i_clk, .i_rstn, .i_clear_pulse(clr), .i_select_pin, .i_regulator_low, .i_osc_fault,
    .i_primary_pin(pins_r[2] ^ flip[2]), .i_secondary_pin(pins_r[1] ^ flip[1]),
    .i_fault_pin(pins_r[0] ^ flip[0]), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_primary_reset_out_n, .o_secondary_reset_out_n, .o_fault_indicator_out_n, .o_supply_off_latch
  );
  wws_mcu_model mcu (.i_clk, .i_period(period), .o_clear_pulse(clr));
  // Board loopback of the pins; flip breaks a pin on purpose
  always_ff @(posedge i_clk) begin
    pins_r <= outs[3:1];
  end
  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic chk_out(input logic [3:0] m, input logic [3:0] v);
    @(negedge i_clk);
    chk({4'h0, outs & m}, {4'h0, v & m});
  endtask : chk_out
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Bounded wait for masked outputs; running out counts as a mismatch
  task automatic wait_out(input logic [3:0] m, input logic [3:0] v, input int lim);
    int n;
    n = 0;
    @(negedge i_clk);
    while (((outs ^ v) & m) !== 4'h0 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= lim) begin
      fails++;
      report_and_stop();
    end
  endtask : wait_out
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask : rd
  task automatic st_is(input int b, input logic e);
    rd(ADDR_STAT);
    chk(d & (8'h01 << b), {7'h00, e} << b);
  endtask : st_is
  task automatic rst(input logic sel);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    i_osc_fault <= 1'b0;
    i_select_pin <= sel;
    flip <= 3'b000;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
  endtask : rst
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {i_rstn, i_select_pin, i_regulator_low, i_osc_fault, i_wr, i_rd} = 6'h00;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    flip = 3'b000;
    period = 16'h0000;
    repeat (8) @(posedge i_clk);
    chk_out(4'hf, 4'b0010);
    i_rstn <= 1'b1;
    repeat (POR - 4) @(posedge i_clk);
    chk_out(4'b1000, 4'b0000);
    wait_out(4'b1000, 4'b1000, 20);
    $display("test power-on reset done");
    for (int k = 0; k < 5; k++) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rd(rows[k].a);
      chk(d, rows[k].e);
    end
    $display("test register rows done");
    period <= 16'h0064;
    wait_out(4'b0100, 4'b0100, 2500);
    rd(ADDR_STATE);
    chk(d & 8'h0f, {4'h0, WWS_RUN});
    $display("test window start done");
    period <= 16'h0014;
    wait_out(4'b0110, 4'b0000, 600);
    st_is(ST_FAST, 1'b1);
    period <= 16'h0064;
    wait_out(4'b0100, 4'b0100, 3000);
    wr(ADDR_STAT, 8'hff);
    wait_out(4'b0010, 4'b0010, 50);
    wr(ADDR_CTRL, 8'h00);
    period <= 16'h0014;
    repeat (400) @(posedge i_clk);
    st_is(ST_FAST, 1'b0);
    chk_out(4'b0110, 4'b0110);
    $display("test fast clear done");
    wr(ADDR_CTRL, 8'h03);
    wait_out(4'b1100, 4'b0000, 600);
    repeat (200) @(posedge i_clk);
    chk_out(4'b1100, 4'b0000);
    @(posedge i_clk);
    i_select_pin <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_select_pin <= 1'b0;
    $display("test latch mode done");
    wr(ADDR_CTRL, 8'h01);
    period <= 16'h0000;
    repeat (12000) @(posedge i_clk);
    rd(ADDR_STATE);
    chk(d, {1'b0, 3'(RST_LATCH_CNT), WWS_LOCK});
    @(posedge i_clk);
    i_select_pin <= 1'b1;
    repeat (20) @(posedge i_clk);
    chk_out(4'b1100, 4'b0000);
    $display("test reset lock done");
    rst(1'b1);
    repeat (POR + 20) @(posedge i_clk);
    chk_out(4'b1100, 4'b1000);
    rd(ADDR_STATE);
    chk(d & 8'h0f, {4'h0, WWS_OFF});
    @(posedge i_clk);
    i_regulator_low <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk_out(4'b1110, 4'b0000);
    st_is(ST_UV, 1'b1);
    @(posedge i_clk);
    i_regulator_low <= 1'b0;
    repeat (POR - 4) @(posedge i_clk);
    chk_out(4'b1000, 4'b0000);
    wait_out(4'b1000, 4'b1000, 20);
    $display("test select and drop done");
    @(posedge i_clk);
    i_osc_fault <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk_out(4'hf, 4'b0001);
    st_is(ST_OSC, 1'b1);
    $display("test oscillator done");
    rst(1'b0);
    wait_out(4'b1000, 4'b1000, POR + 20);
    @(posedge i_clk);
    flip <= 3'b100;
    repeat (10) @(posedge i_clk);
    chk_out(4'b1110, 4'b1100);
    st_is(ST_RPIN, 1'b1);
    rst(1'b0);
    wait_out(4'b1000, 4'b1000, POR + 20);
    @(posedge i_clk);
    flip <= 3'b001;
    repeat (10) @(posedge i_clk);
    chk_out(4'b0010, 4'b0000);
    st_is(ST_FPIN, 1'b1);
    $display("test pin readback done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
